// [hdl/lcs_channel_status.sv]
`timescale 1ns/1ps
// Functional notes
// R1: Error-free slave response received sets the reception-complete flag.
// R2: Framing or checksum error keeps reception flag clear, raises error flag.
// R3: Reception-complete raises channel interrupt only with both enables set.
// R4: Error-free master response sent sets the transmission-complete flag.
// R5: Bit error with halt enabled blocks transmission flag, raises error flag.
// R6: Transmission-complete raises channel interrupt only with both enables set.
// R7: First received data byte stored sets buffer-not-empty flag.
// R8: Buffer-not-empty also set when master transmits the response.
// R9: Software clears buffer-not-empty only after reading all buffers.
// R10: Flags clear on writing one; zero leaves them; reserved bits read zero.
// R11: Initialization request forces all three flags clear.
// R12: In Normal mode, transmitter output recessive when controller not sending.
// R13: Bus dominant past timeout switches master pull-up off, slave stays.
// R14: Bus recessive again re-enables master pull-up and resets timer.
// R15: Four pull-up configurations: off, normal only, normal plus low-power, both.
// R16: Checksum or framing error discards frame, returns controller idle.
// R17: Two-bit per-channel pull-up setting, default trimmed in Normal mode only.
module lcs_channel_status #(
  parameter int NUM_CH = lcs_pkg::NUM_CH,
  parameter int DOM_CNT_W = lcs_pkg::DOM_CNT_W,
  parameter int DOM_TIMEOUT_CYC = lcs_pkg::DOM_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire logic [NUM_CH-1:0] initReq,
  input wire logic [NUM_CH-1:0] haltOnBitErr,
  input wire logic [NUM_CH-1:0] bufDirTx,
  input wire logic [NUM_CH-1:0] rxCompleteIrqEn,
  input wire logic [NUM_CH-1:0] txCompleteIrqEn,
  input wire logic [NUM_CH-1:0] chanStatusIrqEn,
  input wire logic [NUM_CH-1:0] rxFirstByteStored,
  input wire logic [NUM_CH-1:0] rxRespDone,
  input wire logic [NUM_CH-1:0] rxFrameErr,
  input wire logic [NUM_CH-1:0] rxCksumErr,
  input wire logic [NUM_CH-1:0] txRespDone,
  input wire logic [NUM_CH-1:0] txBitErr,
  input wire logic normalMode,
  input wire logic lowPowerMode,
  input wire logic [NUM_CH-1:0] masterTxActive,
  input wire logic [NUM_CH-1:0] masterTxBit,
  input wire logic [NUM_CH-1:0] linRx,
  output logic [NUM_CH-1:0] linTxOut,
  output logic [NUM_CH-1:0] masterPullupOn,
  output logic [NUM_CH-1:0] lowPowerPullupOn,
  output logic [NUM_CH-1:0] domTimeout,
  output logic [NUM_CH-1:0] channelStatusIrq,
  output logic [NUM_CH-1:0] errFrameSet,
  output logic [NUM_CH-1:0] errCksumSet,
  output logic [NUM_CH-1:0] errBitSet,
  output logic [NUM_CH-1:0] masterIdleReq
);

  function automatic logic [7:0] fsOffset(input int ch);
    case (ch)
      0: fsOffset = lcs_pkg::FS_OFFS_CH1;
      1: fsOffset = lcs_pkg::FS_OFFS_CH2;
      2: fsOffset = lcs_pkg::FS_OFFS_CH3;
      default: fsOffset = lcs_pkg::FS_OFFS_CH4;
    endcase
  endfunction : fsOffset

  // Packs the three flags into their register positions, rest zero
  function automatic logic [7:0] fsPack(
    input logic bneBit,
    input logic rxBit,
    input logic txBit
  );
    logic [7:0] v;
    v = lcs_pkg::FS_RST;
    v[lcs_pkg::RXBNE_BIT] = bneBit;
    v[lcs_pkg::RX_DONE_BIT] = rxBit;
    v[lcs_pkg::TX_DONE_BIT] = txBit;
    fsPack = v;
  endfunction : fsPack

  // One status flag: init beats set, set beats a same-cycle clear
  function automatic logic flagNext(
    input logic setEv,
    input logic clrEv,
    input logic initLvl,
    input logic cur
  );
    flagNext = initLvl ? 1'b0 : (setEv || (cur && !clrEv));
  endfunction : flagNext

  // Interrupt pulse needs a real set, no init, and both enables
  function automatic logic irqGate(
    input logic setEv,
    input logic initLvl,
    input logic srcEn,
    input logic chanEn
  );
    irqGate = setEv && !initLvl && srcEn && chanEn;
  endfunction : irqGate

  // Flag state
  logic [NUM_CH-1:0] rxDone_r;
  logic [NUM_CH-1:0] rxDone_nxt;
  logic [NUM_CH-1:0] txDone_r;
  logic [NUM_CH-1:0] txDone_nxt;
  logic [NUM_CH-1:0] rxbne_r;
  logic [NUM_CH-1:0] rxbne_nxt;

  // Config register and read port
  logic [7:0] pullupCfg_r;
  logic [7:0] rdData_r;
  logic rdValid_r;

  // Registered outputs
  logic [NUM_CH-1:0] linTx_r;
  logic [NUM_CH-1:0] irq_r;
  logic [NUM_CH-1:0] errFrame_r;
  logic [NUM_CH-1:0] errCksum_r;
  logic [NUM_CH-1:0] errBit_r;
  logic [NUM_CH-1:0] idleReq_r;

  // Per-channel decode and events
  logic [NUM_CH-1:0] fsHit;
  logic [NUM_CH-1:0] setRx;
  logic [NUM_CH-1:0] setTx;
  logic [NUM_CH-1:0] setBne;
  logic [NUM_CH-1:0] clrRx;
  logic [NUM_CH-1:0] clrTx;
  logic [NUM_CH-1:0] clrBne;
  logic [NUM_CH-1:0] irqRx;
  logic [NUM_CH-1:0] irqTx;
  logic [NUM_CH-1:0] rxErr;
  logic [NUM_CH-1:0] haltBitErr;
  logic [NUM_CH-1:0] txOutNxt;

  // Read path
  logic [7:0] fsWord [NUM_CH];
  logic [7:0] rdMux;

  wire cfgHit = (regAddr == lcs_pkg::PULLUP_CFG_OFFS);

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gCh
      assign fsHit[g] = (regAddr == fsOffset(g));
      assign fsWord[g] = fsPack(rxbne_r[g], rxDone_r[g], txDone_r[g]); // R10
    end

    for (g = 0; g < NUM_CH; g++) begin : gEvt

      assign rxErr[g] = rxFrameErr[g] || rxCksumErr[g];
      assign setRx[g] = rxRespDone[g] && !rxErr[g]; // R1 R2
      assign haltBitErr[g] = txBitErr[g] && haltOnBitErr[g];
      assign setTx[g] = txRespDone[g] && !haltBitErr[g]; // R4 R5
      assign setBne[g] = rxFirstByteStored[g] || (txRespDone[g] && bufDirTx[g]); // R7 R8
    end

    for (g = 0; g < NUM_CH; g++) begin : gClr
      // Clear only on a one written to the bit
      assign clrRx[g] = regWrEn && fsHit[g] && regWrData[lcs_pkg::RX_DONE_BIT]; // R10
      assign clrTx[g] = regWrEn && fsHit[g] && regWrData[lcs_pkg::TX_DONE_BIT]; // R10
      assign clrBne[g] = regWrEn && fsHit[g] && regWrData[lcs_pkg::RXBNE_BIT]; // R10 R9
    end

    for (g = 0; g < NUM_CH; g++) begin : gNxt
      // Software clear loses to a set arriving in the same cycle
      assign rxDone_nxt[g] = flagNext( // R11 R10
        setRx[g],
        clrRx[g],
        initReq[g],
        rxDone_r[g]
      );
      assign txDone_nxt[g] = flagNext( // R11 R10
        setTx[g],
        clrTx[g],
        initReq[g],
        txDone_r[g]
      );
      assign rxbne_nxt[g] = flagNext( // R11 R10
        setBne[g],
        clrBne[g],
        initReq[g],
        rxbne_r[g]
      );
    end

    for (g = 0; g < NUM_CH; g++) begin : gIrq
      // Interrupt pulses only on a real set, gated by both enables
      assign irqRx[g] = irqGate( // R3
        setRx[g],
        initReq[g],
        rxCompleteIrqEn[g],
        chanStatusIrqEn[g]
      );
      assign irqTx[g] = irqGate( // R6
        setTx[g],
        initReq[g],
        txCompleteIrqEn[g],
        chanStatusIrqEn[g]
      );
    end

    for (g = 0; g < NUM_CH; g++) begin : gTx
      // Outside Normal mode the driver is held recessive as well
      assign txOutNxt[g] = (normalMode && masterTxActive[g]) ? masterTxBit[g] // R12
        : lcs_pkg::RECESSIVE;
    end

    for (g = 0; g < NUM_CH; g++) begin : gTerm
      lcs_termination #(
        .CNT_W(DOM_CNT_W),
        .TIMEOUT_CYC(DOM_TIMEOUT_CYC)
      ) uTerm (
        .clk(clk),
        .rst(rst),
        .linRx(linRx[g]),
        .normalMode(normalMode),
        .lowPowerMode(lowPowerMode),
        .pullupCfg(pullupCfg_r[2*g +: 2]), // R17 R15
        .masterPullupOn(masterPullupOn[g]),
        .lowPowerPullupOn(lowPowerPullupOn[g]),
        .domTimeout(domTimeout[g])
      );
    end
  endgenerate

  always_comb begin
    rdMux = lcs_pkg::RD_ZERO;
    if (cfgHit) begin
      rdMux = pullupCfg_r;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (fsHit[i]) begin
        rdMux = fsWord[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxDone_r <= '0;
    end else begin
      rxDone_r <= rxDone_nxt; // R1 R2
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txDone_r <= '0;
    end else begin
      txDone_r <= txDone_nxt; // R4 R5
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxbne_r <= '0;
    end else begin
      rxbne_r <= rxbne_nxt; // R7 R8
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pullupCfg_r <= lcs_pkg::PULLUP_CFG_RST; // R17
    end else if (regWrEn && cfgHit) begin
      pullupCfg_r <= regWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_r <= lcs_pkg::RD_ZERO;
    end else if (regRdEn) begin
      rdData_r <= rdMux;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= regRdEn;
    end
  end

  // Error pulses feed the error-status register kept elsewhere
  always_ff @(posedge clk) begin
    if (rst) begin
      errFrame_r <= '0;
    end else begin
      errFrame_r <= rxRespDone & rxFrameErr; // R2 R16
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      errCksum_r <= '0;
    end else begin
      errCksum_r <= rxRespDone & rxCksumErr; // R2 R16
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      errBit_r <= '0;
    end else begin
      errBit_r <= txBitErr; // R5
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      idleReq_r <= '0;
    end else begin
      idleReq_r <= (rxRespDone & rxErr) | haltBitErr; // R16 R5
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_r <= '0;
    end else begin
      irq_r <= irqRx | irqTx; // R3 R6
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      linTx_r <= {NUM_CH{lcs_pkg::RECESSIVE}};
    end else begin
      linTx_r <= txOutNxt; // R12
    end
  end

  assign regRdData = rdData_r;
  assign regRdValid = rdValid_r;
  assign linTxOut = linTx_r;
  assign channelStatusIrq = irq_r;
  assign errFrameSet = errFrame_r;
  assign errCksumSet = errCksum_r;
  assign errBitSet = errBit_r;
  assign masterIdleReq = idleReq_r;

endmodule : lcs_channel_status

// [hdl/lcs_pkg.sv]
package lcs_pkg;

  localparam int NUM_CH = 4;

  localparam logic [7:0] FS_OFFS_CH1 = 8'h51;
  localparam logic [7:0] FS_OFFS_CH2 = 8'h81;
  localparam logic [7:0] FS_OFFS_CH3 = 8'hB1;
  localparam logic [7:0] FS_OFFS_CH4 = 8'hE1;
  localparam logic [7:0] PULLUP_CFG_OFFS = 8'h20;

  localparam int RXBNE_BIT = 6;
  localparam int RX_DONE_BIT = 2;
  localparam int TX_DONE_BIT = 1;

  localparam logic [7:0] FS_RST = 8'h00;
  localparam logic [7:0] PULLUP_CFG_RST = 8'h55;
  localparam logic [7:0] RD_ZERO = 8'h00;

  typedef enum logic [1:0] {
    PU_OFF = 2'h0,
    PU_NORMAL_ONLY = 2'h1,
    PU_NORMAL_LP = 2'h2,
    PU_ALWAYS = 2'h3
  } lcs_pullup_e;

  localparam logic RECESSIVE = 1'b1;
  localparam logic DOMINANT = 1'b0;

  localparam int CLK_PERIOD_NS = 5;
  localparam int DOM_TIMEOUT_US = 6000;
  localparam int DOM_TIMEOUT_CYC = (DOM_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DOM_CNT_W = 21;

endpackage : lcs_pkg

// [hdl/lcs_termination.sv]
`timescale 1ns/1ps
module lcs_termination #(
  parameter int CNT_W = lcs_pkg::DOM_CNT_W,
  parameter int TIMEOUT_CYC = lcs_pkg::DOM_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic linRx,
  input wire logic normalMode,
  input wire logic lowPowerMode,
  input wire logic [1:0] pullupCfg,
  output logic masterPullupOn,
  output logic lowPowerPullupOn,
  output logic domTimeout
);

  logic linSync1_r;
  logic linSync2_r;
  logic [CNT_W-1:0] domCnt_r;
  logic [CNT_W-1:0] domCnt_nxt;
  logic domTimeout_r;
  logic domTimeout_nxt;
  logic masterOn_r;
  logic lpOn_r;

  localparam logic [CNT_W-1:0] LIMIT = CNT_W'(TIMEOUT_CYC);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  wire busRecessive = (linSync2_r == lcs_pkg::RECESSIVE);
  wire limitHit = (domCnt_r >= LIMIT);
  wire cfgOff = (pullupCfg == lcs_pkg::PU_OFF);
  wire cfgAlways = (pullupCfg == lcs_pkg::PU_ALWAYS);
  wire cfgNormLp = (pullupCfg == lcs_pkg::PU_NORMAL_LP);
  // Slave pull-up stays on outside; only master paths are gated
  wire masterWant = (normalMode && !cfgOff) || (lowPowerMode && cfgAlways); // R15
  wire lpWant = lowPowerMode && cfgNormLp; // R15

  // Counter saturates so a long stuck bus never wraps back on
  assign domCnt_nxt = busRecessive ? '0 : (limitHit ? domCnt_r : domCnt_r + ONE); // R14
  assign domTimeout_nxt = busRecessive ? 1'b0 : (domTimeout_r || limitHit); // R13

  always_ff @(posedge clk) begin
    linSync1_r <= linRx;
    linSync2_r <= linSync1_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      domCnt_r <= '0;
      domTimeout_r <= 1'b0;
      masterOn_r <= 1'b0;
      lpOn_r <= 1'b0;
    end else begin
      domCnt_r <= domCnt_nxt;
      domTimeout_r <= domTimeout_nxt;
      masterOn_r <= masterWant && !domTimeout_nxt; // R13 R14
      lpOn_r <= lpWant && !domTimeout_nxt; // R13 R14
    end
  end

  assign masterPullupOn = masterOn_r;
  assign lowPowerPullupOn = lpOn_r;
  assign domTimeout = domTimeout_r;

endmodule : lcs_termination

// [verif/lcs_channel_status_props.sv]
`timescale 1ns/1ps
module lcs_channel_status_props #(
  parameter int DOM_TIMEOUT_CYC = lcs_pkg::DOM_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic [3:0] initReq,
  input wire logic [3:0] haltOnBitErr,
  input wire logic [3:0] rxCompleteIrqEn,
  input wire logic [3:0] txCompleteIrqEn,
  input wire logic [3:0] chanStatusIrqEn,
  input wire logic [3:0] rxRespDone,
  input wire logic [3:0] rxFrameErr,
  input wire logic [3:0] rxCksumErr,
  input wire logic [3:0] txRespDone,
  input wire logic [3:0] txBitErr,
  input wire logic normalMode,
  input wire logic [3:0] masterTxActive,
  input wire logic [3:0] linRx,
  input wire logic [3:0] linTxOut,
  input wire logic [3:0] masterPullupOn,
  input wire logic [3:0] domTimeout,
  input wire logic [3:0] channelStatusIrq,
  input wire logic [3:0] errBitSet,
  input wire logic [3:0] masterIdleReq
);
  int domCnt_r;
  // Raw bus time; the design sees it two syncs late, hence the margins
  always_ff @(posedge clk) begin
    if (rst || linRx[0]) begin
      domCnt_r <= 0;
    end else begin
      domCnt_r <= domCnt_r + 1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_rxOk;
    rxRespDone[0] && !rxFrameErr[0] && !rxCksumErr[0] && !initReq[0] && !txRespDone[0];
  endsequence
  sequence s_txOk;
    txRespDone[0] && !(txBitErr[0] && haltOnBitErr[0]) && !initReq[0] && !rxRespDone[0];
  endsequence
  sequence s_recess;
    linRx[0] [*4];
  endsequence
  property p_rsvd;
    regRdEn && (regAddr inside {8'h51, 8'h81, 8'hB1, 8'hE1}) |=> (regRdData & 8'hB9) == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");
  property p_rxIrq;
    s_rxOk ##0 (rxCompleteIrqEn[0] && chanStatusIrqEn[0]) |-> ##[1:2] channelStatusIrq[0];
  endproperty
  a_rxIrq: assert property (p_rxIrq) else $error("rx irq missing");
  property p_rxErr;
    rxRespDone[0] && (rxFrameErr[0] || rxCksumErr[0]) |=> !channelStatusIrq[0] && masterIdleReq[0];
  endproperty
  a_rxErr: assert property (p_rxErr) else $error("rx error handling wrong");
  property p_txMask;
    s_txOk ##0 !(txCompleteIrqEn[0] && chanStatusIrqEn[0]) |=> !channelStatusIrq[0] [*2];
  endproperty
  a_txMask: assert property (p_txMask) else $error("masked tx irq raised");
  property p_txHalt;
    txRespDone[0] && txBitErr[0] && haltOnBitErr[0] |-> ##[1:2] (errBitSet[0] && masterIdleReq[0]);
  endproperty
  a_txHalt: assert property (p_txHalt) else $error("halted bit error missed");
  property p_init;
    initReq[0] [*2] |-> !channelStatusIrq[0];
  endproperty
  a_init: assert property (p_init) else $error("irq during init");
  property p_txIdle;
    normalMode && !masterTxActive[0] |=> linTxOut[0];
  endproperty
  a_txIdle: assert property (p_txIdle) else $error("idle tx not recessive");
  property p_domOff;
    domCnt_r == DOM_TIMEOUT_CYC + 6 |-> domTimeout[0] && !masterPullupOn[0];
  endproperty
  a_domOff: assert property (p_domOff) else $error("pull-up kept on");
  property p_domEarly;
    domCnt_r > 4 && domCnt_r < DOM_TIMEOUT_CYC - 2 |-> !domTimeout[0];
  endproperty
  a_domEarly: assert property (p_domEarly) else $error("timeout too early");
  property p_domBack;
    s_recess |-> !domTimeout[0];
  endproperty
  a_domBack: assert property (p_domBack) else $error("timeout not cleared");
endmodule : lcs_channel_status_props
bind lcs_channel_status lcs_channel_status_props #(.DOM_TIMEOUT_CYC(DOM_TIMEOUT_CYC)) u_props (.*);

// [verif/lcs_lin_bus_model.sv]
`timescale 1ns/1ps
module lcs_lin_bus_model (
  input wire logic [3:0] linTxOut,
  input wire logic [3:0] slaveDom,
  output logic [3:0] linRx
);
  // Wired-AND bus; the pull-up makes it recessive once nobody pulls low
  assign linRx = linTxOut & ~slaveDom;
endmodule : lcs_lin_bus_model

// [verif/lin_channel_status_termination_bench.sv]
`timescale 1ns/1ps
module lin_channel_status_termination_bench;
  localparam int TO = 20;
  logic clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0, normalMode = 1'b1, lowPowerMode = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic regRdValid;
  logic [3:0] initReq = 4'h0, haltOnBitErr = 4'h0, bufDirTx = 4'h0, rxCompleteIrqEn = 4'h5;
  logic [3:0] txCompleteIrqEn = 4'hA, chanStatusIrqEn = 4'h7, rxFirstByteStored = 4'h0, rxRespDone = 4'h0;
  logic [3:0] rxFrameErr = 4'h0, rxCksumErr = 4'h0, txRespDone = 4'h0, txBitErr = 4'h0, slaveDom = 4'h0;
  logic [3:0] masterTxActive = 4'h0, masterTxBit = 4'h0, linRx, linTxOut, masterPullupOn, lowPowerPullupOn;
  logic [3:0] domTimeout, channelStatusIrq, errFrameSet, errCksumSet, errBitSet, masterIdleReq;
  logic [7:0] fs [4] = '{lcs_pkg::FS_OFFS_CH1, lcs_pkg::FS_OFFS_CH2, lcs_pkg::FS_OFFS_CH3, lcs_pkg::FS_OFFS_CH4};
  logic [7:0] txExp [3] = '{8'h02, 8'h40, 8'h42};
  int failures = 0;
  int checkCount = 0;
  lcs_channel_status #(.DOM_TIMEOUT_CYC(TO)) u_dut (.*);
  lcs_lin_bus_model u_bus (.linTxOut(linTxOut), .slaveDom(slaveDom), .linRx(linRx));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic step(int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Gap cycle after each access keeps strobes from being re-driven in one step
  task automatic wr(logic [7:0] a, logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    step(1);
    regWrEn = 1'b0;
    step(1);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    regAddr = a;
    regRdEn = 1'b1;
    step(1);
    regRdEn = 1'b0;
    chk(regRdData, e);
    chk({7'h0, regRdValid}, 8'h01);
    step(1);
  endtask : rd
  // Pulse outputs stand one cycle, so they are looked at mid-task
  task automatic go(logic [7:0] eIrq, logic [7:0] eErr, logic [3:0] eBit);
    step(1);
    {rxFirstByteStored, rxRespDone, rxFrameErr, rxCksumErr, txRespDone, txBitErr} = 24'h0;
    chk({channelStatusIrq, masterIdleReq}, eIrq);
    chk({errFrameSet, errCksumSet}, eErr);
    chk({4'h0, errBitSet}, {4'h0, eBit});
    step(1);
  endtask : go
  task automatic close_out;
    if (failures == 0 && checkCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    close_out();
  end
  initial begin
    step(10);
    rst = 1'b0;
    step(3);
    foreach (fs[c]) rd(fs[c], lcs_pkg::FS_RST);
    rd(lcs_pkg::PULLUP_CFG_OFFS, lcs_pkg::PULLUP_CFG_RST);
    wr(8'h33, 8'hFF);
    rd(8'h33, 8'h00);
    foreach (fs[c]) begin
      rxFirstByteStored[c] = 1'b1;
      rxRespDone[c] = 1'b1;
      go({(4'h1 << c) & 4'h5, 4'h0}, 8'h00, 4'h0);
      rd(fs[c], 8'h44);
      wr(fs[c], 8'hBB);
      rd(fs[c], 8'h44);
      wr(fs[c], 8'h04);
      rd(fs[c], 8'h40);
      wr(fs[c], 8'h40);
      rd(fs[c], 8'h00);
    end
    rxRespDone = 4'h3;
    rxFrameErr = 4'h1;
    rxCksumErr = 4'h2;
    go(8'h03, 8'h12, 4'h0);
    rd(fs[0], 8'h00);
    rd(fs[1], 8'h00);
    for (int h = 0; h < 3; h++) begin
      bufDirTx = {4{h != 0}};
      haltOnBitErr = {4{h != 0}};
      txBitErr = {3'h0, h < 2};
      txRespDone = 4'h1;
      go({7'h0, h == 1}, 8'h00, {3'h0, h < 2});
      rd(fs[0], txExp[h]);
      wr(fs[0], 8'h42);
    end
    txRespDone = 4'h2;
    go(8'h20, 8'h00, 4'h0);
    rxRespDone = 4'h1;
    go(8'h10, 8'h00, 4'h0);
    initReq = 4'h1;
    step(1);
    rd(fs[0], 8'h00);
    rxRespDone = 4'h1;
    txRespDone = 4'h1;
    go(8'h00, 8'h00, 4'h0);
    rd(fs[0], 8'h00);
    initReq = 4'h0;
    masterTxActive = 4'hF;
    masterTxBit = 4'h6;
    step(2);
    chk({4'h0, linTxOut}, 8'h06);
    masterTxActive = 4'h0;
    step(2);
    chk({4'h0, linTxOut}, 8'h0F);
    for (int g = 0; g < 4; g++) begin
      wr(lcs_pkg::PULLUP_CFG_OFFS, {4{g[1:0]}});
      rd(lcs_pkg::PULLUP_CFG_OFFS, {4{g[1:0]}});
      normalMode = 1'b1;
      lowPowerMode = 1'b0;
      step(2);
      chk({masterPullupOn, lowPowerPullupOn}, (g > 0) ? 8'hF0 : 8'h00);
      normalMode = 1'b0;
      lowPowerMode = 1'b1;
      step(2);
      chk({masterPullupOn, lowPowerPullupOn}, (g == 3) ? 8'hF0 : ((g == 2) ? 8'h0F : 8'h00));
    end
    normalMode = 1'b1;
    lowPowerMode = 1'b0;
    slaveDom = 4'h1;
    step(TO + 8);
    chk({domTimeout, masterPullupOn}, 8'h1E);
    slaveDom = 4'h0;
    step(4);
    chk({domTimeout, masterPullupOn}, 8'h0F);
    close_out();
  end
endmodule : lin_channel_status_termination_bench
